// File: core/pvt_pkg.sv
/*
 * pvt_pkg: constants of the periodic interval timer: register map,
 * field positions, reset values and the divide-by-16 tick.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
// Functional notes
// - a 20-bit interval counter and a 12-bit elapsed counter advance on a clock/16 tick.
// - the interval counter counts up from zero, wraps to zero at the limit and bumps the elapsed count.
// - every wrap sets the period flag, and the interrupt is high while that flag, its enable and the irq mask bit are all set.
// - writing a new limit leaves both counters untouched.
// - reading the acknowledging value register returns both counts, then clears the elapsed count and the flag unless a wrap lands in the same cycle.
// - reading the peek register returns the same counts with no side effect.
// - a change of the enable bit only takes effect while the interval counter is zero.
// - once disabled the counter runs on to the limit, wraps to zero and stays there until enabled.
// - reset leaves the timer disabled and the mode register at limit 0xFFFFF with both enables clear.
// - both counters freeze while the core is in debug state.
// - one interval lasts limit plus one ticks.
// - mode holds the limit in bits 19..0, the timer enable in bit 24 and the interrupt enable in bit 25.
// - value and peek return the interval count in bits 19..0 and the elapsed count in bits 31..20.
// - the elapsed field counts periods since the last acknowledging read; the flag is status bit 0.
package pvt_pkg;
    localparam int unsigned CNT_W        = 20;
    localparam int unsigned ELAPSED_W    = 12;
    localparam int unsigned PRESC_W      = 4;
    localparam logic [3:0]  PRESC_LAST   = 4'hf;

    localparam logic [7:0]  OFS_MODE     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_VAL_ACK  = 8'h08;
    localparam logic [7:0]  OFS_VAL_PEEK = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;

    localparam int unsigned BIT_TEN      = 24;
    localparam int unsigned BIT_IEN      = 25;
    localparam int unsigned BIT_FLAG     = 0;
    localparam int unsigned BIT_ELAPSED  = 20;

    localparam logic [19:0] RST_LIMIT    = 20'hf_ffff;
    localparam logic        RST_TEN      = 1'b0;
    localparam logic        RST_IEN      = 1'b0;
    localparam logic        RST_MASK     = 1'b1;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
endpackage

// File: core/pvt_top.sv
/*
 * pvt_top: periodic interval timer with an AHB-Lite register slave.
 * Assumes a single master, sys_clk at 25 MHz, and debug_halt coming
 * from core logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pvt_top (
    // clock, reset, enable
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    input  wire logic                     ce,
    // core status
    input  wire logic                     debug_halt,
    // ahb-lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    // interrupt
    output logic                          tick_irq
);
    import pvt_pkg::*;

    function automatic logic [31:0] pvt_pack_value(input logic [11:0] el, input logic [19:0] cv);
        pvt_pack_value = {el, cv};
    endfunction

    // gray along idle -> data phase -> idle
    typedef enum logic [1:0] {
        PVT_BUS_IDLE = 2'b00,
        PVT_BUS_RD   = 2'b01,
        PVT_BUS_WR   = 2'b10
    } pvt_bus_t;

    logic [3:0]           presc_q;
    logic [CNT_W-1:0]     interval_count_q;
    logic [ELAPSED_W-1:0] elapsed_interval_count_q;
    logic                 period_reached_flag_q;
    logic [CNT_W-1:0]     interval_limit_q;
    logic                 timer_enable_bit_q;
    logic                 tick_irq_enable_q;
    logic                 irq_mask_q;
    logic                 irq_q;
    pvt_bus_t             bus_state_q;
    pvt_bus_t             bus_state_d;
    logic [7:0]           addr_q;
    logic                 hreadyout_q;
    logic                 hresp_q;
    logic [31:0]          hrdata_q;

    logic                 accept;
    logic                 rd_do;
    logic                 wr_do;
    logic                 ack_rd;
    logic                 peek_rd;
    logic                 mode_wr;
    logic                 status_w1c;
    logic                 tick;
    logic                 run;
    logic                 wrap;

    // bus decode; upper address bits are not decoded, so the map aliases
    assign accept     = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
    assign rd_do      = bus_state_q == PVT_BUS_RD;
    assign wr_do      = bus_state_q == PVT_BUS_WR;
    assign ack_rd     = ce && rd_do && addr_q == OFS_VAL_ACK;
    assign peek_rd    = ce && rd_do && addr_q == OFS_VAL_PEEK;
    assign mode_wr    = ce && wr_do && addr_q == OFS_MODE;
    assign status_w1c = ce && wr_do && addr_q == OFS_STATUS && hwdata[BIT_FLAG];

    // divided tick; the prescaler stops with the counters in debug
    assign tick = ce && !debug_halt && presc_q == PRESC_LAST;
    // a zero count with enable low is the only idle point
    assign run  = interval_count_q != '0 || timer_enable_bit_q;
    assign wrap = tick && run && interval_count_q == interval_limit_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            presc_q <= '0;
        end else if (ce && !debug_halt) begin
            presc_q <= presc_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            interval_count_q <= '0;
        end else if (tick && run) begin
            if (wrap) begin
                interval_count_q <= '0;
            end else begin
                interval_count_q <= interval_count_q + 20'h0_0001;
            end
        end
    end

    // increment beats the acknowledge clear, so no period is lost
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            elapsed_interval_count_q <= '0;
        end else if (wrap && ack_rd) begin
            elapsed_interval_count_q <= 12'h001;
        end else if (wrap) begin
            elapsed_interval_count_q <= elapsed_interval_count_q + 12'h001;
        end else if (ack_rd) begin
            elapsed_interval_count_q <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            period_reached_flag_q <= 1'b0;
        end else if (wrap) begin
            period_reached_flag_q <= 1'b1;
        end else if (ack_rd || status_w1c) begin
            period_reached_flag_q <= 1'b0;
        end
    end

    // mode write touches only mode fields, never the counters
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            interval_limit_q   <= RST_LIMIT;
            timer_enable_bit_q <= RST_TEN;
            tick_irq_enable_q  <= RST_IEN;
        end else if (mode_wr) begin
            interval_limit_q   <= hwdata[CNT_W-1:0];
            timer_enable_bit_q <= hwdata[BIT_TEN];
            tick_irq_enable_q  <= hwdata[BIT_IEN];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_q <= RST_MASK;
        end else if (ce && wr_do && addr_q == OFS_IRQ_MASK) begin
            irq_mask_q <= hwdata[BIT_FLAG];
        end
    end

    // registered level: one cycle behind the flag
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= period_reached_flag_q && tick_irq_enable_q && irq_mask_q;
        end
    end

    // next bus phase; a data phase always lasts one cycle
    always_comb begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            PVT_BUS_IDLE: begin
                if (accept) begin
                    bus_state_d = hwrite ? PVT_BUS_WR : PVT_BUS_RD;
                end
            end
            PVT_BUS_RD, PVT_BUS_WR: begin
                if (accept) begin
                    bus_state_d = hwrite ? PVT_BUS_WR : PVT_BUS_RD;
                end else begin
                    bus_state_d = PVT_BUS_IDLE;
                end
            end
            default: begin
                bus_state_d = PVT_BUS_IDLE;
            end
        endcase
    end

    // one wait state per transfer keeps hrdata straight from a flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus_state_q <= PVT_BUS_IDLE;
            addr_q      <= '0;
            hreadyout_q <= 1'b1;
        end else if (ce) begin
            bus_state_q <= bus_state_d;
            if (accept) begin
                addr_q      <= haddr[7:0];
                hreadyout_q <= 1'b0;
            end else begin
                hreadyout_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hresp_q <= 1'b0;
        end else if (ce) begin
            hresp_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata_q <= '0;
        end else if (ce && rd_do) begin
            case (addr_q)
                OFS_MODE: begin
                    hrdata_q <= {6'h00, tick_irq_enable_q, timer_enable_bit_q,
                                 4'h0, interval_limit_q};
                end
                OFS_STATUS: begin
                    hrdata_q <= {31'h0, period_reached_flag_q};
                end
                OFS_VAL_ACK: begin
                    hrdata_q <= pvt_pack_value(elapsed_interval_count_q, interval_count_q);
                end
                OFS_VAL_PEEK: begin
                    hrdata_q <= pvt_pack_value(elapsed_interval_count_q, interval_count_q);
                end
                OFS_IRQ_MASK: begin
                    hrdata_q <= {31'h0, irq_mask_q};
                end
                default: begin
                    hrdata_q <= '0;
                end
            endcase
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign hrdata    = hrdata_q;
    assign tick_irq  = irq_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // bus handshake steps
    sequence s_accept;
        accept && ce;
    endsequence
    sequence s_answer;
        !hreadyout_q ##1 hreadyout_q;
    endsequence
    // a read that lands in the data register
    sequence s_read_done;
        rd_do && ce;
    endsequence

    chk_bus_answer: assert property (s_accept ##1 ce |-> s_answer)
        else $error("bus answer not after one wait state");

    chk_bus_okay: assert property (!hresp_q)
        else $error("bus response not okay");

    chk_data_hold: assert property (!(rd_do && ce) |=> $stable(hrdata_q))
        else $error("read data changed without a read");

    chk_read_mode: assert property (s_read_done ##0 (addr_q == OFS_MODE)
        |=> hrdata_q == {6'h00, $past(tick_irq_enable_q), $past(timer_enable_bit_q),
                         4'h0, $past(interval_limit_q)})
        else $error("mode read wrong");

    chk_read_status: assert property (s_read_done ##0 (addr_q == OFS_STATUS)
        |=> hrdata_q == {31'h0, $past(period_reached_flag_q)})
        else $error("status read wrong");

    chk_peek_data: assert property (peek_rd
        |=> hrdata_q == {$past(elapsed_interval_count_q), $past(interval_count_q)})
        else $error("peek read wrong");

    chk_tick_divide: assert property (tick |=> presc_q == 4'h0)
        else $error("prescaler did not restart after tick");

    chk_prescale_step: assert property (ce && !debug_halt |=> presc_q == $past(presc_q) + 4'h1)
        else $error("prescaler did not step");

    chk_count_step: assert property (tick && run && !wrap
        |=> interval_count_q == $past(interval_count_q) + 20'h0_0001)
        else $error("interval count did not step");

    chk_count_hold: assert property (!(tick && run) |=> $stable(interval_count_q))
        else $error("interval count moved without a tick");

    chk_wrap_elapsed: assert property (wrap && !ack_rd
        |=> interval_count_q == '0
            && elapsed_interval_count_q == $past(elapsed_interval_count_q) + 12'h001)
        else $error("wrap did not clear count and bump elapsed");

    chk_elapsed_hold: assert property (!wrap && !ack_rd |=> $stable(elapsed_interval_count_q))
        else $error("elapsed count moved without a wrap");

    chk_flag_set: assert property (wrap |=> period_reached_flag_q)
        else $error("period flag not set on wrap");

    chk_flag_hold: assert property (!wrap && !ack_rd && !status_w1c
        |=> $stable(period_reached_flag_q))
        else $error("period flag changed on its own");

    chk_w1c_clear: assert property (status_w1c && !wrap |=> !period_reached_flag_q)
        else $error("write one did not clear flag");

    chk_irq_level: assert property (ce && period_reached_flag_q && tick_irq_enable_q
        && irq_mask_q |=> tick_irq)
        else $error("interrupt not raised");

    chk_irq_quiet: assert property (ce && !period_reached_flag_q |=> !tick_irq)
        else $error("interrupt without flag");

    chk_irq_disabled: assert property (ce && !tick_irq_enable_q |=> !tick_irq)
        else $error("interrupt while disabled");

    chk_mode_keep: assert property (mode_wr && !tick |=> $stable(interval_count_q)
        && $stable(elapsed_interval_count_q))
        else $error("mode write disturbed counters");

    chk_mode_write: assert property (mode_wr
        |=> interval_limit_q == $past(hwdata[CNT_W-1:0])
            && timer_enable_bit_q == $past(hwdata[BIT_TEN])
            && tick_irq_enable_q == $past(hwdata[BIT_IEN]))
        else $error("mode write did not land");

    chk_ack_clear: assert property (ack_rd && !wrap
        |=> elapsed_interval_count_q == '0 && !period_reached_flag_q
            && hrdata_q == {$past(elapsed_interval_count_q), $past(interval_count_q)})
        else $error("acknowledging read wrong");

    chk_ack_wrap: assert property (wrap && ack_rd
        |=> elapsed_interval_count_q == 12'h001 && period_reached_flag_q)
        else $error("wrap lost against acknowledge");

    chk_peek_keep: assert property (peek_rd && !wrap && !status_w1c
        |=> $stable(elapsed_interval_count_q) && $stable(period_reached_flag_q))
        else $error("peek read had a side effect");

    chk_idle_hold: assert property (interval_count_q == '0 && !timer_enable_bit_q
        |=> interval_count_q == '0)
        else $error("counter left zero while disabled");

    chk_debug_freeze: assert property (debug_halt |=> $stable(interval_count_q)
        && $stable(presc_q))
        else $error("counter moved in debug state");

    chk_ce_freeze: assert property (!ce |=> $stable(presc_q) && $stable(interval_count_q)
        && $stable(elapsed_interval_count_q) && $stable(hreadyout_q))
        else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// File: testbench/periodic_interval_timer_tb.sv
/*
 * periodic_interval_timer_tb: self-checking bench for pvt_top, with
 * register access over AHB-Lite and checks of timing, ack and freeze.
 * Assumes pvt_pkg is compiled first; every bus wait is bounded.
 */
`timescale 1ns/100ps
`default_nettype none
module periodic_interval_timer_tb;
    import pvt_pkg::*;
    logic        sys_clk, rstn, ce, debug_halt, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, v1;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, tick_irq;
    wire logic   hready;
    int          error_cnt, checked;
    time         t0;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    pvt_top DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .debug_halt(debug_halt),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .tick_irq(tick_irq));

    task automatic stop_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for a signal level, sampled at rising edges
    task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge sys_clk);
            if (sig === lvl) break;
        end
        if (n == lim) begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0000_00, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_lvl(hreadyout, 1'b1, 50);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_lvl(hreadyout, 1'b1, 50);
        rd = hrdata;
        cmp({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0000_0000, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0000_0000, d);
        cmp(d, exp);
    endtask

    initial begin
        rstn = 1'b0; ce = 1'b1; debug_halt = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000;
        htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        error_cnt = 0; checked = 0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rdc(OFS_MODE, 32'h000f_ffff);
        rdc(OFS_STATUS, 32'h0000_0000);
        rdc(8'h14, 32'h0000_0000);
        repeat (100) @(posedge sys_clk);
        rdc(OFS_VAL_PEEK, 32'h0000_0000);
        cmp({31'h0, tick_irq}, 32'h0000_0000);
        // limit 3: one period is 4 ticks of 16 clocks
        wr(OFS_MODE, 32'h0300_0003);
        rdc(OFS_MODE, 32'h0300_0003);
        wait_lvl(tick_irq, 1'b1, 200);
        t0 = $time;
        rdc(OFS_STATUS, 32'h0000_0001);
        rdc(OFS_VAL_ACK, 32'h0010_0000);
        wait_lvl(tick_irq, 1'b0, 10);
        wait_lvl(tick_irq, 1'b1, 200);
        cmp(32'(($time - t0) / 40), 32'd64);
        // frozen core: both counts and flag hold still; an acknowledging read clears the elapsed count and flag
        debug_halt <= 1'b1;
        rd(OFS_VAL_PEEK, v1);
        repeat (40) @(posedge sys_clk);
        rdc(OFS_VAL_PEEK, v1);
        rdc(OFS_STATUS, 32'h0000_0001);
        rdc(OFS_VAL_ACK, v1);
        cmp(v1, 32'h0010_0000);
        rdc(OFS_VAL_PEEK, v1 & 32'h000f_ffff);
        rdc(OFS_STATUS, 32'h0000_0000);
        cmp({31'h0, tick_irq}, 32'h0000_0000);
        wr(OFS_MODE, 32'h0300_0007);
        rdc(OFS_VAL_PEEK, v1 & 32'h000f_ffff);
        debug_halt <= 1'b0;
        // new limit 7 gives 128 clocks between wraps
        wait_lvl(tick_irq, 1'b1, 300);
        t0 = $time;
        rd(OFS_VAL_ACK, v1);
        wait_lvl(tick_irq, 1'b0, 10);
        wait_lvl(tick_irq, 1'b1, 300);
        cmp(32'(($time - t0) / 40), 32'd128);
        // clock enable low: 64 clocks would be 4 ticks if it ran
        ce <= 1'b0;
        repeat (64) @(posedge sys_clk);
        ce <= 1'b1;
        rdc(OFS_VAL_PEEK, 32'h0010_0000);
        // mask and write-one-clear of the flag
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        cmp({31'h0, tick_irq}, 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        cmp({31'h0, tick_irq}, 32'h0000_0001);
        wr(OFS_STATUS, 32'h0000_0001);
        rdc(OFS_STATUS, 32'h0000_0000);
        // disable: runs on to the limit, then rests at zero
        wr(OFS_MODE, 32'h0200_0007);
        repeat (300) @(posedge sys_clk);
        rd(OFS_VAL_PEEK, v1);
        cmp({12'h000, v1[19:0]}, 32'h0000_0000);
        repeat (200) @(posedge sys_clk);
        rdc(OFS_VAL_PEEK, v1);
        wr(OFS_MODE, 32'h0300_0007);
        repeat (40) @(posedge sys_clk);
        rd(OFS_VAL_PEEK, v1);
        cmp({31'h0, v1[19:0] != 20'h0_0000}, 32'h0000_0001);
        stop_test();
    end
endmodule
`default_nettype wire
